// ### include/slbmc_pkg.sv
package slbmc_pkg;
	// register indices; byte address is four times the index
	localparam logic [11:0] IDX_CONTROL   = 12'h000;
	localparam logic [11:0] IDX_LINK      = 12'h001;
	localparam logic [11:0] IDX_FORMAT    = 12'h002;
	localparam logic [11:0] IDX_LANE_RATE = 12'h003;
	localparam logic [11:0] IDX_ADC_RATE  = 12'h004;
	localparam logic [11:0] IDX_STATUS    = 12'h005;
	localparam logic [11:0] IDX_PLL_BAND  = 12'h56e;
	localparam logic [11:0] IDX_NONE      = 12'hfff;

	// reset values and writable masks
	localparam logic [31:0] RST_CONTROL   = 32'h00000000;
	localparam logic [31:0] RST_LINK      = 32'h20010111;
	localparam logic [31:0] RST_FORMAT    = 32'h00000108;
	localparam logic [31:0] RST_RATE      = 32'h00000000;
	localparam logic [31:0] RST_PLL_BAND  = 32'h00000000;
	localparam logic [31:0] MASK_CONTROL  = 32'h00000003;
	localparam logic [31:0] MASK_LINK     = 32'hbf0f1fff;
	localparam logic [31:0] MASK_FORMAT   = 32'h00001f3f;
	localparam logic [31:0] MASK_RATE     = 32'h0000ffff;
	localparam logic [31:0] MASK_PLL_BAND = 32'h000000ff;

	// control bits
	localparam int CTRL_RUN     = 0;
	localparam int CTRL_CONFIRM = 1;

	// status bits
	localparam int ST_CFG_OK  = 0;
	localparam int ST_WINDOW  = 1;
	localparam int ST_DIVIDER = 2;
	localparam int ST_LCM     = 3;
	localparam int ST_RATIO   = 4;
	localparam int ST_KF      = 5;
	localparam int ST_COMBO   = 6;
	localparam int ST_DECIM   = 7;
	localparam int ST_FORMAT  = 8;
	localparam int ST_BAND    = 9;
	localparam int ST_UNSET   = 10;
	localparam int ST_RUNNING = 11;
	localparam int ST_WIDTH   = 12;

	// lane and sample rates in half-Mbps units
	localparam logic [15:0] RATE_MIN  = 16'h0d2f;
	localparam logic [15:0] RATE_B1   = 16'h1a5e;
	localparam logic [15:0] RATE_B2   = 16'h34bc;
	localparam logic [15:0] RATE_B3   = 16'h6978;
	localparam logic [15:0] RATE_MAX  = 16'h7918;
	localparam logic [7:0]  DIV_RATIO = 8'h28;
	localparam logic [7:0]  LCM_MAX   = 8'h40;
	localparam logic [7:0]  LANE_MULT = 8'h0a;
	localparam logic [5:0]  K_MAX     = 6'h20;
	localparam logic [7:0]  PLL_HIGH  = 8'h30;
	localparam logic [7:0]  PLL_MID   = 8'h10;

	localparam logic [1:0]  SP_OKAY   = 2'h0;
	localparam logic [1:0]  SP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		GRP_NONE = 3'b000,
		GRP_L1M1 = 3'b001,
		GRP_X5   = 3'b010,
		GRP_L4M1 = 3'b011,
		GRP_L1M2 = 3'b100,
		GRP_L2M2 = 3'b101
	} slbmc_group_t;
endpackage : slbmc_pkg

// ### logic/slbmc_link_config.sv
// Operation
// - K times F divisible by 4, K<=32
// - lanes, converters, octets, samples, frames framing
// - 8-bit words, resolution 7-8, 0-1 control bits
// - high-density flag held at zero
// - one lane two converters, decimation up to 30
// - two lanes two converters, decimation by band
`timescale 1ns/1ns
module slbmc_link_config (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [15:0] awaddr,
	input  wire logic [2:0]  awprot,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [15:0] araddr,
	input  wire logic [2:0]  arprot,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic [7:0]  smp_data,
	input  wire logic        smp_valid,
	output logic             smp_ready,
	output logic [7:0]       oct_data,
	output logic             oct_valid,
	input  wire logic        oct_ready,
	output logic             oct_frame_end,
	output logic             oct_mf_end
);
	function automatic logic [11:0] reg_index(input logic [15:0] a);
		reg_index = (a[15:14] != 2'h0) ? slbmc_pkg::IDX_NONE : a[13:2];
	endfunction : reg_index

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] st, input logic [31:0] m);
		logic [31:0] be;
		be = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}} & m;
		merge = (old & ~be) | (nw & be);
	endfunction : merge

	function automatic slbmc_pkg::slbmc_group_t combo(input logic [16:0] k);
		case (k)
			{4'h1, 4'h1, 5'h01, 4'h1}, {4'h1, 4'h1, 5'h02, 4'h2}:
				combo = slbmc_pkg::GRP_L1M1;
			{4'h2, 4'h1, 5'h01, 4'h2}, {4'h2, 4'h1, 5'h02, 4'h4},
			{4'h2, 4'h1, 5'h04, 4'h8}, {4'h4, 4'h2, 5'h01, 4'h2},
			{4'h4, 4'h2, 5'h02, 4'h4}, {4'h4, 4'h2, 5'h04, 4'h8}:
				combo = slbmc_pkg::GRP_X5;
			{4'h4, 4'h1, 5'h01, 4'h4}, {4'h4, 4'h1, 5'h02, 4'h8}:
				combo = slbmc_pkg::GRP_L4M1;
			{4'h1, 4'h2, 5'h02, 4'h1}:
				combo = slbmc_pkg::GRP_L1M2;
			{4'h2, 4'h2, 5'h01, 4'h1}, {4'h2, 4'h2, 5'h02, 4'h2}:
				combo = slbmc_pkg::GRP_L2M2;
			default:
				combo = slbmc_pkg::GRP_NONE;
		endcase
	endfunction : combo

	// allowed decimation set, bit n for ratio n
	function automatic logic [31:0] decim_mask(input logic [2:0] g,
		input logic [1:0] b);
		case ({g, b})
			5'b001_00: decim_mask = 32'h0000157e;
			5'b001_01: decim_mask = 32'h0000017e;
			5'b001_10: decim_mask = 32'h0000001e;
			5'b001_11: decim_mask = 32'h00000006;
			5'b010_00: decim_mask = 32'h0000017e;
			5'b010_01: decim_mask = 32'h0000001e;
			5'b010_10: decim_mask = 32'h00000006;
			5'b010_11: decim_mask = 32'h00000002;
			5'b011_00: decim_mask = 32'h0000001e;
			5'b011_01: decim_mask = 32'h00000006;
			5'b011_10: decim_mask = 32'h00000002;
			5'b100_00: decim_mask = 32'h41119574;
			5'b100_01: decim_mask = 32'h0001957e;
			5'b100_10: decim_mask = 32'h0000017e;
			5'b100_11: decim_mask = 32'h0000001e;
			5'b101_00: decim_mask = 32'h0001957e;
			5'b101_01: decim_mask = 32'h0000017e;
			5'b101_10: decim_mask = 32'h0000001e;
			5'b101_11: decim_mask = 32'h00000006;
			default:   decim_mask = 32'h00000000;
		endcase
	endfunction : decim_mask

	logic [31:0] ctrl, link_cfg, fmt, lane_rate, adc_rate, pll_band;
	logic [15:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        aw_have, w_have;
	logic [slbmc_pkg::ST_WIDTH-1:0] st;
	logic [7:0]  skid_data;
	logic        skid_valid;
	logic [4:0]  oct_cnt;
	logic [5:0]  frm_cnt;

	// configuration fields
	wire [3:0]  lanes                 = link_cfg[3:0];
	wire [3:0]  convs                 = link_cfg[7:4];
	wire [4:0]  octs                  = link_cfg[12:8];
	wire [3:0]  samps                 = link_cfg[19:16];
	wire [5:0]  kfr                   = link_cfg[29:24];
	wire        high_density_flag     = link_cfg[31];
	wire [3:0]  res                   = fmt[3:0];
	wire [1:0]  cbits                 = fmt[5:4];
	wire [4:0]  chip_decimation_ratio = fmt[12:8];
	wire [15:0] serial_lane_rate      = lane_rate[15:0];
	wire [15:0] fadc                  = adc_rate[15:0];

	wire slbmc_pkg::slbmc_group_t grp = combo({lanes, convs, octs, samps});
	wire combo_ok = grp != slbmc_pkg::GRP_NONE;
	wire [1:0] band = (serial_lane_rate > slbmc_pkg::RATE_B3) ? 2'h3 :
		(serial_lane_rate >= slbmc_pkg::RATE_B2) ? 2'h2 :
		(serial_lane_rate >= slbmc_pkg::RATE_B1) ? 2'h1 : 2'h0;
	wire [31:0] allowed = decim_mask(grp, band);
	wire decim_ok = (chip_decimation_ratio != 5'h00) &&
		allowed[chip_decimation_ratio];
	wire window_ok = (serial_lane_rate >= slbmc_pkg::RATE_MIN) &&
		(serial_lane_rate <= slbmc_pkg::RATE_MAX);
	wire [23:0] div_lim = fadc * slbmc_pkg::DIV_RATIO;
	wire div_ok = {8'h00, serial_lane_rate} <= div_lim;
	// lcm term reduces to decimation times a group power of two
	wire [1:0] lsh = (grp == slbmc_pkg::GRP_L1M2) ? 2'h0 :
		(grp == slbmc_pkg::GRP_X5) ? 2'h2 :
		(grp == slbmc_pkg::GRP_L4M1) ? 2'h3 : 2'h1;
	wire [7:0] lcm_term = {3'h0, chip_decimation_ratio} << lsh;
	wire lcm_ok = lcm_term <= slbmc_pkg::LCM_MAX;
	// lane rate = 10*M*fadc/(L*decimation), fout = fadc/decimation
	wire [31:0] ratio_lhs = 32'(serial_lane_rate) * 32'(lanes) *
		32'(chip_decimation_ratio);
	wire [31:0] ratio_rhs = 32'(fadc) * 32'(convs) *
		32'(slbmc_pkg::LANE_MULT);
	wire ratio_ok = ratio_lhs == ratio_rhs;
	wire [10:0] kf = 11'(kfr) * 11'(octs);
	wire [5:0] kmin = (octs == 5'h01) ? 6'h14 : (octs == 5'h02) ? 6'h0c :
		(octs == 5'h04) ? 6'h08 :
		(octs == 5'h08 || octs == 5'h10) ? 6'h04 : 6'h3f;
	wire kf_ok = (kf[1:0] == 2'h0) && (kfr[1:0] == 2'h0) &&
		(kfr <= slbmc_pkg::K_MAX) && (kfr >= kmin);
	wire fmt_ok = !high_density_flag && (res == 4'h7 || res == 4'h8) &&
		(cbits <= 2'h1);
	wire low_band = band == 2'h0 || band == 2'h1;
	wire band_ok = (band == 2'h3) ? pll_band[7:0] == slbmc_pkg::PLL_HIGH :
		(band == 2'h2) ? pll_band[7:0] == slbmc_pkg::PLL_MID :
		ctrl[slbmc_pkg::CTRL_CONFIRM];
	wire cfg_ok = window_ok && div_ok && lcm_ok && ratio_ok && kf_ok &&
		combo_ok && decim_ok && fmt_ok && band_ok;
	wire run = ctrl[slbmc_pkg::CTRL_RUN] && cfg_ok;
	wire [slbmc_pkg::ST_WIDTH-1:0] next_st = {run, low_band, band_ok,
		fmt_ok, decim_ok, combo_ok, kf_ok, ratio_ok, lcm_ok, div_ok,
		window_ok, cfg_ok};

	// register bus
	wire [11:0] wr_idx = reg_index(aw_addr);
	wire [11:0] rd_idx = reg_index(araddr);
	wire do_write = aw_have && w_have && !bvalid;
	wire wr_hit = wr_idx == slbmc_pkg::IDX_CONTROL ||
		wr_idx == slbmc_pkg::IDX_LINK || wr_idx == slbmc_pkg::IDX_FORMAT ||
		wr_idx == slbmc_pkg::IDX_LANE_RATE ||
		wr_idx == slbmc_pkg::IDX_ADC_RATE ||
		wr_idx == slbmc_pkg::IDX_PLL_BAND;
	wire rd_hit = wr_hit_r(rd_idx) || rd_idx == slbmc_pkg::IDX_STATUS;
	wire [31:0] rd_mux =
		(rd_idx == slbmc_pkg::IDX_CONTROL)   ? ctrl :
		(rd_idx == slbmc_pkg::IDX_LINK)      ? link_cfg :
		(rd_idx == slbmc_pkg::IDX_FORMAT)    ? fmt :
		(rd_idx == slbmc_pkg::IDX_LANE_RATE) ? lane_rate :
		(rd_idx == slbmc_pkg::IDX_ADC_RATE)  ? adc_rate :
		(rd_idx == slbmc_pkg::IDX_PLL_BAND)  ? pll_band :
		(rd_idx == slbmc_pkg::IDX_STATUS)    ?
		{{(32 - slbmc_pkg::ST_WIDTH){1'b0}}, st} : 32'h00000000;

	function automatic logic wr_hit_r(input logic [11:0] i);
		wr_hit_r = i == slbmc_pkg::IDX_CONTROL || i == slbmc_pkg::IDX_LINK ||
			i == slbmc_pkg::IDX_FORMAT || i == slbmc_pkg::IDX_LANE_RATE ||
			i == slbmc_pkg::IDX_ADC_RATE || i == slbmc_pkg::IDX_PLL_BAND;
	endfunction : wr_hit_r

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready <= 1'b0;
			wready  <= 1'b0;
			aw_have <= 1'b0;
			w_have  <= 1'b0;
			aw_addr <= 16'h0000;
			w_data  <= 32'h00000000;
			w_strb  <= 4'h0;
			bvalid  <= 1'b0;
			bresp   <= slbmc_pkg::SP_OKAY;
		end
		else
		begin
			awready <= !aw_have && !bvalid && !(awvalid && awready);
			wready  <= !w_have && !bvalid && !(wvalid && wready);
			if (awvalid && awready)
			begin
				aw_have <= 1'b1;
				aw_addr <= awaddr;
			end
			if (wvalid && wready)
			begin
				w_have <= 1'b1;
				w_data <= wdata;
				w_strb <= wstrb;
			end
			if (do_write)
			begin
				aw_have <= 1'b0;
				w_have  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= wr_hit ? slbmc_pkg::SP_OKAY : slbmc_pkg::SP_SLVERR;
			end
			else if (bvalid && bready)
				bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl      <= slbmc_pkg::RST_CONTROL;
			link_cfg  <= slbmc_pkg::RST_LINK;
			fmt       <= slbmc_pkg::RST_FORMAT;
			lane_rate <= slbmc_pkg::RST_RATE;
			adc_rate  <= slbmc_pkg::RST_RATE;
			pll_band  <= slbmc_pkg::RST_PLL_BAND;
		end
		else if (do_write)
		begin
			if (wr_idx == slbmc_pkg::IDX_CONTROL)
				ctrl <= merge(ctrl, w_data, w_strb, slbmc_pkg::MASK_CONTROL);
			if (wr_idx == slbmc_pkg::IDX_LINK)
				link_cfg <= merge(link_cfg, w_data, w_strb, slbmc_pkg::MASK_LINK);
			if (wr_idx == slbmc_pkg::IDX_FORMAT)
				fmt <= merge(fmt, w_data, w_strb, slbmc_pkg::MASK_FORMAT);
			if (wr_idx == slbmc_pkg::IDX_LANE_RATE)
				lane_rate <= merge(lane_rate, w_data, w_strb, slbmc_pkg::MASK_RATE);
			if (wr_idx == slbmc_pkg::IDX_ADC_RATE)
				adc_rate <= merge(adc_rate, w_data, w_strb, slbmc_pkg::MASK_RATE);
			if (wr_idx == slbmc_pkg::IDX_PLL_BAND)
				pll_band <= merge(pll_band, w_data, w_strb,
					slbmc_pkg::MASK_PLL_BAND);
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h00000000;
			rresp   <= slbmc_pkg::SP_OKAY;
			st      <= '0;
		end
		else
		begin
			st <= next_st;
			if (arvalid && arready)
			begin
				arready <= 1'b0;
				rvalid  <= 1'b1;
				rdata   <= rd_mux;
				rresp   <= rd_hit ? slbmc_pkg::SP_OKAY : slbmc_pkg::SP_SLVERR;
			end
			else if (rvalid && rready)
				rvalid <= 1'b0;
			else if (!rvalid)
				arready <= 1'b1;
		end
	end

	// two-entry octet path: output stage plus skid entry
	wire accept = smp_valid && smp_ready;
	wire advance = !oct_valid || oct_ready;
	wire load = advance && (skid_valid || accept);
	wire next_skid_valid = advance ? 1'b0 : (skid_valid || accept);
	wire frame_last = oct_cnt == octs - 5'h01;
	wire mf_last = frame_last && (frm_cnt == kfr - 6'h01);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			smp_ready     <= 1'b0;
			skid_valid    <= 1'b0;
			skid_data     <= 8'h00;
			oct_valid     <= 1'b0;
			oct_data      <= 8'h00;
			oct_frame_end <= 1'b0;
			oct_mf_end    <= 1'b0;
			oct_cnt       <= 5'h00;
			frm_cnt       <= 6'h00;
		end
		else
		begin
			smp_ready  <= run && !next_skid_valid;
			skid_valid <= next_skid_valid;
			if (!advance && accept)
				skid_data <= smp_data;
			if (advance)
				oct_valid <= skid_valid || accept;
			if (load)
			begin
				oct_data      <= skid_valid ? skid_data : smp_data;
				oct_frame_end <= frame_last;
				oct_mf_end    <= mf_last;
				oct_cnt       <= frame_last ? 5'h00 : oct_cnt + 5'h01;
				if (frame_last)
					frm_cnt <= mf_last ? 6'h00 : frm_cnt + 6'h01;
			end
			else if (!run && !oct_valid && !skid_valid)
			begin
				oct_cnt <= 5'h00;
				frm_cnt <= 6'h00;
			end
		end
	end

	window_chk_a: assert property (@(posedge aclk) disable iff (!aresetn)
		st[slbmc_pkg::ST_WINDOW] |->
		($past(serial_lane_rate) >= slbmc_pkg::RATE_MIN &&
		$past(serial_lane_rate) <= slbmc_pkg::RATE_MAX))
		else $error("lane rate window flagged wrongly");
	divider_chk_a: assert property (@(posedge aclk) disable iff (!aresetn)
		st[slbmc_pkg::ST_DIVIDER] |-> $past(24'(serial_lane_rate)) <=
		24'(40) * $past(24'(fadc)))
		else $error("divider check flagged wrongly");
	lcm_limit_a: assert property (@(posedge aclk) disable iff (!aresetn)
		st[slbmc_pkg::ST_CFG_OK] |-> $past(lcm_term) <= 8'h40)
		else $error("lcm term above limit accepted");
	kf_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
		st[slbmc_pkg::ST_KF] |-> ($past(kf) % 4 == 0 && $past(kfr) <= 6'h20))
		else $error("frame count check flagged wrongly");
	band_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(st[slbmc_pkg::ST_BAND] && $past(serial_lane_rate) > 16'h6978) |->
		$past(pll_band[7:0]) == 8'h30)
		else $error("high band value wrong");
	band_mid_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(st[slbmc_pkg::ST_BAND] && $past(serial_lane_rate) >= 16'h34bc &&
		$past(serial_lane_rate) <= 16'h6978) |->
		$past(pll_band[7:0]) == 8'h10)
		else $error("mid band value wrong");
	band_confirm_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(st[slbmc_pkg::ST_BAND] && st[slbmc_pkg::ST_UNSET]) |->
		$past(ctrl[slbmc_pkg::CTRL_CONFIRM]))
		else $error("low band accepted without confirmation");
	hd_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
		st[slbmc_pkg::ST_FORMAT] |-> !$past(high_density_flag))
		else $error("high density accepted");
	run_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
		smp_ready |-> st[slbmc_pkg::ST_CFG_OK])
		else $error("samples taken with invalid configuration");
	stall_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(oct_valid && !oct_ready) |=> (oct_valid && $stable(oct_data) &&
		$stable(oct_frame_end)))
		else $error("octet lost under stall");
endmodule : slbmc_link_config

// ### verif/slbmc_rx_model.sv
`timescale 1ns/1ns
module slbmc_rx_model (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  oct_data,
	input  wire logic        oct_valid,
	output logic             oct_ready,
	input  wire logic        oct_frame_end,
	input  wire logic        oct_mf_end,
	input  wire logic        slow,
	input  wire logic        stall,
	input  wire logic [7:0]  f_oct,
	input  wire logic [7:0]  k_frm,
	output logic [15:0]      got,
	output logic [15:0]      errs
);
	logic [1:0]  ph;
	logic [15:0] next_got;
	logic        exp_fe;
	logic        exp_me;
	assign next_got = got + 16'h0001;
	// frame closes every f octets, multiframe every k frames
	assign exp_fe = (next_got % f_oct) == 16'h0000;
	assign exp_me = (next_got % (f_oct * k_frm)) == 16'h0000;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ph        <= 2'h0;
			oct_ready <= 1'b0;
			got       <= 16'h0000;
			errs      <= 16'h0000;
		end
		else
		begin
			ph        <= ph + 2'h1;
			// slow receiver drops ready one cycle in four
			oct_ready <= !stall && (!slow || ph != 2'h3);
			if (oct_valid && oct_ready)
			begin
				got <= next_got;
				if (oct_data !== got[7:0] || oct_frame_end !== exp_fe
					|| oct_mf_end !== exp_me)
					errs <= errs + 16'h0001;
			end
		end
	end
endmodule : slbmc_rx_model

// ### verif/test_slbmc_link_config.sv
`timescale 1ns/1ns
module test_slbmc_link_config;
	localparam logic [15:0] A_CTRL = 16'h0000;
	localparam logic [15:0] A_LINK = 16'h0004;
	localparam logic [15:0] A_FMT  = 16'h0008;
	localparam logic [15:0] A_LANE = 16'h000c;
	localparam logic [15:0] A_ADC  = 16'h0010;
	localparam logic [15:0] A_STAT = 16'h0014;
	localparam logic [15:0] A_PLL  = 16'h15b8;
	localparam logic [31:0] BASE   = 32'h0c010221;
	localparam logic [31:0] FM     = 32'h00000108;
	localparam logic [1:0]  OK     = slbmc_pkg::SP_OKAY;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready;
	logic        bvalid, bready, arvalid, arready, rvalid, rready;
	logic        smp_valid, smp_ready, oct_valid, oct_ready;
	logic        oct_frame_end, oct_mf_end, slow, stall;
	logic [1:0]  bresp, rresp;
	logic [7:0]  smp_data, oct_data;
	logic [15:0] awaddr, araddr, got, errs, seq;
	logic [31:0] wdata, rdata;
	int          bad_count = 0, n_compared = 0, cyc = 0;

	slbmc_link_config u_slbmc_link_config (
		.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready,
		.wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready,
		.araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .smp_data, .smp_valid, .smp_ready, .oct_data,
		.oct_valid, .oct_ready, .oct_frame_end, .oct_mf_end
	);
	slbmc_rx_model u_slbmc_rx_model (
		.aclk, .aresetn, .oct_data, .oct_valid, .oct_ready, .oct_frame_end,
		.oct_mf_end, .slow, .stall, .f_oct(8'h02), .k_frm(8'h0c), .got,
		.errs
	);

	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
	begin
		n_compared++;
		if (g !== e)
		begin
			bad_count++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	end
	endtask : cmp

	task automatic axi_wr(input logic [15:0] a, input logic [31:0] d,
		input logic [1:0] er);
	begin
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		while (bvalid !== 1'b1)
		begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
		end
		cmp({30'h0, bresp}, {30'h0, er});
		bready <= 1'b0;
		@(posedge aclk);
	end
	endtask : axi_wr

	task automatic rd_chk(input logic [15:0] a, input logic [31:0] m,
		input logic [31:0] e, input logic [1:0] er);
	begin
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		while (rvalid !== 1'b1)
		begin
			@(posedge aclk);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
		end
		cmp(rdata & m, e);
		cmp({30'h0, rresp}, {30'h0, er});
		rready <= 1'b0;
		@(posedge aclk);
	end
	endtask : rd_chk

	task automatic cfg(input logic [31:0] lk, input logic [31:0] fm,
		input logic [15:0] ln, input logic [15:0] ad, input logic [7:0] pb,
		input logic [1:0] ct, input logic ok_exp);
	begin
		axi_wr(A_LINK, lk, OK);
		axi_wr(A_FMT, fm, OK);
		axi_wr(A_LANE, {16'h0, ln}, OK);
		axi_wr(A_ADC, {16'h0, ad}, OK);
		axi_wr(A_PLL, {24'h0, pb}, OK);
		axi_wr(A_CTRL, {30'h0, ct}, OK);
		// status trails the registers by one cycle
		repeat (3) @(posedge aclk);
		rd_chk(A_STAT, 32'h1, {31'h0, ok_exp}, OK);
	end
	endtask : cfg

	task automatic push(input int n, input int lim);
		int t;
		int k;
	begin
		k = 0;
		smp_valid <= 1'b1;
		smp_data  <= seq[7:0];
		for (t = 0; t < lim && k < n; t++)
		begin
			@(posedge aclk);
			if (smp_ready === 1'b1)
			begin
				k++;
				seq = seq + 16'h1;
				smp_data <= seq[7:0];
			end
		end
		smp_valid <= 1'b0;
		@(posedge aclk);
	end
	endtask : push

	task automatic give_verdict();
	begin
		$display("compared %0d bad %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
	endtask : give_verdict

	initial
	begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			bad_count++;
			give_verdict();
		end
	end

	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{smp_valid, slow, stall, awaddr, araddr, wdata, smp_data} = '0;
		seq = 16'h0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd_chk(A_CTRL, '1, slbmc_pkg::RST_CONTROL, OK);
		rd_chk(A_LINK, '1, slbmc_pkg::RST_LINK, OK);
		rd_chk(A_FMT, '1, slbmc_pkg::RST_FORMAT, OK);
		rd_chk(A_PLL, '1, slbmc_pkg::RST_PLL_BAND, OK);
		rd_chk(16'h0100, '1, 32'h0, slbmc_pkg::SP_SLVERR);
		axi_wr(16'h0100, 32'h1, slbmc_pkg::SP_SLVERR);
		axi_wr(A_LINK, '1, OK);
		rd_chk(A_LINK, '1, slbmc_pkg::MASK_LINK, OK);
		axi_wr(A_PLL, 32'hffffffa5, OK);
		rd_chk(A_PLL, '1, 32'h000000a5, OK);
		cmp({31'h0, smp_ready}, 32'h0);
		cfg(BASE, FM, 16'h4e20, 16'h03e8, 8'h10, 2'h0, 1'b1);
		cfg(32'h08010221, FM, 16'h4e20, 16'h03e8, 8'h10, 2'h0, 1'b0);
		cfg(32'h0e010221, FM, 16'h4e20, 16'h03e8, 8'h10, 2'h0, 1'b0);
		cfg(32'h8c010221, FM, 16'h4e20, 16'h03e8, 8'h10, 2'h0, 1'b0);
		cfg(32'h0c010231, FM, 16'h4e20, 16'h03e8, 8'h10, 2'h0, 1'b0);
		cfg(BASE, FM, 16'h4e20, 16'h03e8, 8'h30, 2'h0, 1'b0);
		cfg(BASE, FM, 16'h6d60, 16'h0578, 8'h30, 2'h0, 1'b1);
		cfg(BASE, FM, 16'h6d60, 16'h0578, 8'h10, 2'h0, 1'b0);
		cfg(BASE, FM, 16'h7918, 16'h060e, 8'h30, 2'h0, 1'b1);
		cfg(BASE, FM, 16'h7a00, 16'h0620, 8'h30, 2'h0, 1'b0);
		rd_chk(A_STAT, 32'h2, 32'h0, OK);
		cfg(BASE, FM, 16'h4e20, 16'h01f0, 8'h10, 2'h0, 1'b0);
		rd_chk(A_STAT, 32'h4, 32'h0, OK);
		cfg(32'h14020112, 32'h1f08, 16'h4e20, 16'h1f40, 8'h10, 2'h0, 1'b0);
		rd_chk(A_STAT, 32'h8, 32'h0, OK);
		cfg(BASE, FM, 16'h1f40, 16'h0190, 8'h10, 2'h0, 1'b0);
		cfg(BASE, FM, 16'h1f40, 16'h0190, 8'h50, 2'h2, 1'b1);
		cfg(BASE, 32'h1e08, 16'h0fa0, 16'h1770, 8'h00, 2'h2, 1'b1);
		cfg(32'h14010122, 32'h0408, 16'h4e20, 16'h1f40, 8'h10, 2'h0, 1'b1);
		cfg(32'h14010122, 32'h0508, 16'h4e20, 16'h2710, 8'h10, 2'h0, 1'b0);
		cfg(BASE, FM, 16'h4e20, 16'h03e8, 8'h10, 2'h1, 1'b1);
		rd_chk(A_STAT, 32'h801, 32'h801, OK);
		slow <= 1'b1;
		push(48, 400);
		repeat (20) @(posedge aclk);
		cmp({16'h0, got}, 32'd48);
		stall <= 1'b1;
		repeat (4) @(posedge aclk);
		fork
			push(30, 400);
			begin
				repeat (12) @(posedge aclk);
				cmp({31'h0, smp_ready}, 32'h0);
				stall <= 1'b0;
			end
		join
		repeat (20) @(posedge aclk);
		cmp({16'h0, got}, {16'h0, seq});
		cmp({16'h0, errs}, 32'h0);
		give_verdict();
	end
endmodule : test_slbmc_link_config
